/* File: rtl/sild_defs.vh */
// constants for the system register and integer latency decoder
`ifndef SILD_DEFS_VH
`define SILD_DEFS_VH

// instruction fields
`define SILD_PRI_HI        31
`define SILD_PRI_LO        26
`define SILD_EXT_HI        10
`define SILD_EXT_LO        1

// primary opcodes
`define SILD_P_TRAPI       6'h03
`define SILD_P_MULI        6'h07
`define SILD_P_SUBFIC      6'h08
`define SILD_P_CMPLI       6'h0a
`define SILD_P_CMPI        6'h0b
`define SILD_P_ADDIC       6'h0c
`define SILD_P_ADDICR      6'h0d
`define SILD_P_ADDI        6'h0e
`define SILD_P_ADDIS       6'h0f
`define SILD_P_SYSCALL     6'h11
`define SILD_P_GRP19       6'h13
`define SILD_P_ROTMI       6'h14
`define SILD_P_ROTM        6'h15
`define SILD_P_ROTMN       6'h17
`define SILD_P_LOG_LO      6'h18
`define SILD_P_LOG_HI      6'h1d
`define SILD_P_GRP31       6'h1f

// 64-bit architected primaries (illegal here)
`define SILD_P64_A         6'h02
`define SILD_P64_B         6'h1e
`define SILD_P64_C         6'h3a
`define SILD_P64_D         6'h3e

// primary 19 extended codes
`define SILD_X_CPCF        10'h000
`define SILD_X_RFI         10'h032
`define SILD_X_CRNOR       10'h021
`define SILD_X_CRANDC      10'h081
`define SILD_X_ISYNC       10'h096
`define SILD_X_CRXOR       10'h0c1
`define SILD_X_CRNAND      10'h0e1
`define SILD_X_CRAND       10'h101
`define SILD_X_CREQV       10'h121
`define SILD_X_CRORC       10'h1a1
`define SILD_X_CROR        10'h1c1

// primary 31 extended codes, system and condition register
`define SILD_X_RDCR        10'h013
`define SILD_X_RDMSR       10'h053
`define SILD_X_WRCRF       10'h090
`define SILD_X_WRMSR       10'h092
`define SILD_X_WRSEG       10'h0d2
`define SILD_X_WRSEGI      10'h0f2
`define SILD_X_RDSPR       10'h153
`define SILD_X_RDTB        10'h173
`define SILD_X_WRSPR       10'h1d3
`define SILD_X_XCPCR       10'h200
`define SILD_X_RDSEG       10'h253
`define SILD_X_MSYNC       10'h256
`define SILD_X_RDSEGI      10'h293
`define SILD_X_IOBAR       10'h356

// primary 31 extended codes, integer
`define SILD_X_CMP         10'h000
`define SILD_X_TRAPW       10'h004
`define SILD_X_MULHU       10'h00b
`define SILD_X_CMPL        10'h020
`define SILD_X_MULHS       10'h04b
`define SILD_X_MULLO       10'h0eb
`define SILD_X_ADD         10'h10a
`define SILD_X_DIVU        10'h1cb
`define SILD_X_DIVS        10'h1eb

// primary 31 64-bit extended codes (illegal here)
`define SILD_X64_A         10'h009
`define SILD_X64_B         10'h015
`define SILD_X64_C         10'h01b
`define SILD_X64_D         10'h03a
`define SILD_X64_E         10'h044
`define SILD_X64_F         10'h049
`define SILD_X64_G         10'h1c9
`define SILD_X64_H         10'h1e9
`define SILD_X64_I         10'h3da

// special register numbers, plain defaults
`define SILD_SPR_XER       10'h001
`define SILD_SPR_TBL       10'h11c
`define SILD_SPR_TBU       10'h11d
`define SILD_SPR_IBAT_LO   10'h210
`define SILD_SPR_IBAT_HI   10'h217
`define SILD_SPR_DBAT_LO   10'h218
`define SILD_SPR_DBAT_HI   10'h21f

// unit codes, one-hot
`define SILD_UNIT_NONE     3'h0
`define SILD_UNIT_INT      3'h1
`define SILD_UNIT_SRU      3'h2

// latency figures in cycles
`define SILD_LAT_1         5'h01
`define SILD_LAT_2         5'h02
`define SILD_LAT_3         5'h03
`define SILD_LAT_DIV       5'h14
`define SILD_MULI_MAX      3'h1
`define SILD_MULHU_MAX     3'h4
`define SILD_MULS_MAX      3'h3

`endif

/* File: rtl/sild_lat_timer.v */
// latency countdown timer for the decoder
`timescale 1ns/1ps
module sild_lat_timer
(
   ref_clk,
   rst_b,
   load,
   load_val,
   done_ff
);
   input  wire       ref_clk;
   input  wire       rst_b;
   input  wire       load;
   input  wire [4:0] load_val;
   output reg        done_ff;

   reg [4:0] cnt_ff;
   reg [4:0] nxt_cnt;

   always @*
   begin
      nxt_cnt = cnt_ff;
      if (load)
         nxt_cnt = load_val;
      else if (cnt_ff != 5'h00)
         nxt_cnt = cnt_ff - 5'h01;
   end

   // done stands in the cycle before edge load_val, so the decoder finishes on that very edge
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff  <= 5'h00;
         done_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= nxt_cnt;
         done_ff <= load ? (load_val == 5'h01) : (cnt_ff == 5'h02);
      end
   end
endmodule

/* File: rtl/sild_decoder.v */
// system register, condition register and integer latency decoder
// Function
// - return_from_interrupt 19/050 runs in sysreg_exec_unit, three cycles
// - instruction_barrier 19/150 runs in sysreg_exec_unit, one cycle plus serialization
// - machine state and segment register writes 146/210/242 take two cycles
// - special register read one cycle; block translation reads three plus serialization
// - special register write two cycles, time base one; exception reg or instr blocks serialize
// - segment register read 595 takes three cycles plus serialization
// - memory sync 598 one cycle plus serialization; io barrier 854 one cycle
// - time base read and write each take one cycle
// - serializing instructions take listed cycles plus a variable serialization wait
// - condition bit operations under primary 19 take one cycle
// - condition read/write one cycle; exception copy 512 one plus serialization
// - compares take one cycle on either unit and forward condition to branch_unit
// - only register add 266 may use sysreg_exec_unit; other arithmetic uses integer
// - mult_immediate primary 07 takes two or three integer cycles
// - mult_high_unsigned 31/011 takes two to five integer cycles
// - mult_high_signed 075 and mult_low 235 take two to five cycles
// - divides 459 and 491 take twenty integer cycles
// - trap_immediate and trap_word take two integer cycles
// - rotate, logical, shift, extend, count and add/subtract take one cycle
// - 64-bit encodings are not executed and raise the illegal flag
// - latency counts from execution start until the result is ready
`timescale 1ns/1ps
`include "sild_defs.vh"
module sild_decoder
(
   ref_clk,
   rst_b,
   dec_valid,
   dec_instr,
   op_b,
   int_busy,
   sru_busy,
   ser_release,
   accept_ff,
   unit_ff,
   lat_ff,
   serial_ff,
   cr_fwd_ff,
   illegal_ff,
   foreign_ff,
   res_valid_ff,
   total_ff
);
   input  wire        ref_clk;
   input  wire        rst_b;
   input  wire        dec_valid;
   input  wire [31:0] dec_instr;
   input  wire [31:0] op_b;
   input  wire        int_busy;
   input  wire        sru_busy;
   input  wire        ser_release;
   output reg         accept_ff;
   output reg  [2:0]  unit_ff;
   output reg  [4:0]  lat_ff;
   output reg         serial_ff;
   output reg         cr_fwd_ff;
   output reg         illegal_ff;
   output reg         foreign_ff;
   output reg         res_valid_ff;
   output reg  [7:0]  total_ff;

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_EXEC = 3'h2;
   localparam [2:0] ST_SER  = 3'h4;

   // count of significant bytes of a 32-bit magnitude, 0 to 4
   function [2:0] sig_bytes;
      input [31:0] v;
      begin
         if (v[31:24] != 8'h00)
            sig_bytes = 3'h4;
         else if (v[23:16] != 8'h00)
            sig_bytes = 3'h3;
         else if (v[15:8] != 8'h00)
            sig_bytes = 3'h2;
         else if (v[7:0] != 8'h00)
            sig_bytes = 3'h1;
         else
            sig_bytes = 3'h0;
      end
   endfunction

   // two cycles plus one per extra byte, capped at the listed top
   function [4:0] mul_lat;
      input [31:0] v;
      input        sgn;
      input [2:0]  max_extra;
      reg   [31:0] mag;
      reg   [2:0]  nb;
      reg   [2:0]  extra;
      begin
         mag   = sgn ? (v ^ {32{v[31]}}) : v;
         nb    = sig_bytes(mag);
         extra = (nb == 3'h0) ? 3'h0 : nb - 3'h1;
         if (extra > max_extra)
            extra = max_extra;
         mul_lat = `SILD_LAT_2 + {2'h0, extra};
      end
   endfunction

   wire [5:0] pri = dec_instr[`SILD_PRI_HI:`SILD_PRI_LO];
   wire [9:0] ext = dec_instr[`SILD_EXT_HI:`SILD_EXT_LO];
   wire [9:0] spr = {dec_instr[15:11], dec_instr[20:16]};

   wire spr_ibat = (spr >= `SILD_SPR_IBAT_LO) && (spr <= `SILD_SPR_IBAT_HI);
   wire spr_dbat = (spr >= `SILD_SPR_DBAT_LO) && (spr <= `SILD_SPR_DBAT_HI);
   wire spr_tb   = (spr == `SILD_SPR_TBL) || (spr == `SILD_SPR_TBU);
   // dual-issue pick: sysreg unit only when integer unit is taken and it is free
   wire use_sru  = int_busy && !sru_busy;

   reg       d_known;
   reg       d_ill;
   reg [2:0] d_unit;
   reg [4:0] d_lat;
   reg       d_ser;
   reg       d_crf;

   always @*
   begin
      d_known = 1'b1;
      d_ill   = 1'b0;
      d_unit  = `SILD_UNIT_INT;
      d_lat   = `SILD_LAT_1;
      d_ser   = 1'b0;
      d_crf   = 1'b0;
      case (pri)
         `SILD_P_SYSCALL:
         begin
            d_unit = `SILD_UNIT_SRU;
            d_lat  = `SILD_LAT_3;
         end
         `SILD_P_TRAPI:
            d_lat = `SILD_LAT_2;
         `SILD_P_MULI:
            d_lat = mul_lat(op_b, 1'b1, `SILD_MULI_MAX);
         `SILD_P_CMPLI, `SILD_P_CMPI:
         begin
            d_unit = use_sru ? `SILD_UNIT_SRU : `SILD_UNIT_INT;
            d_crf  = 1'b1;
         end
         `SILD_P_SUBFIC, `SILD_P_ADDIC, `SILD_P_ADDICR, `SILD_P_ADDI, `SILD_P_ADDIS,
         `SILD_P_ROTMI, `SILD_P_ROTM, `SILD_P_ROTMN:
            d_lat = `SILD_LAT_1;
         `SILD_P64_A, `SILD_P64_B, `SILD_P64_C, `SILD_P64_D:
            d_ill = 1'b1;
         `SILD_P_GRP19:
         begin
            d_unit = `SILD_UNIT_SRU;
            case (ext)
               `SILD_X_RFI:
                  d_lat = `SILD_LAT_3;
               `SILD_X_ISYNC:
                  d_ser = 1'b1;
               `SILD_X_CPCF, `SILD_X_CRNOR, `SILD_X_CRANDC, `SILD_X_CRXOR,
               `SILD_X_CRNAND, `SILD_X_CRAND, `SILD_X_CREQV, `SILD_X_CRORC,
               `SILD_X_CROR:
                  d_lat = `SILD_LAT_1;
               default:
               begin
                  d_known = 1'b0;
                  d_unit  = `SILD_UNIT_NONE;
               end
            endcase
         end
         `SILD_P_GRP31:
         begin
            case (ext)
               `SILD_X_RDMSR:
                  d_unit = `SILD_UNIT_SRU;
               `SILD_X_WRMSR, `SILD_X_WRSEG, `SILD_X_WRSEGI:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  d_lat  = `SILD_LAT_2;
               end
               `SILD_X_RDSPR:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  if (spr_ibat || spr_dbat)
                  begin
                     d_lat = `SILD_LAT_3;
                     d_ser = 1'b1;
                  end
               end
               `SILD_X_WRSPR:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  d_lat  = spr_tb ? `SILD_LAT_1 : `SILD_LAT_2;
                  d_ser  = (spr == `SILD_SPR_XER) || spr_ibat;
               end
               `SILD_X_RDSEG, `SILD_X_RDSEGI:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  d_lat  = `SILD_LAT_3;
                  d_ser  = 1'b1;
               end
               `SILD_X_MSYNC:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  d_ser  = 1'b1;
               end
               `SILD_X_IOBAR, `SILD_X_RDTB, `SILD_X_RDCR, `SILD_X_WRCRF:
                  d_unit = `SILD_UNIT_SRU;
               `SILD_X_XCPCR:
               begin
                  d_unit = `SILD_UNIT_SRU;
                  d_ser  = 1'b1;
               end
               `SILD_X_CMP, `SILD_X_CMPL:
               begin
                  d_unit = use_sru ? `SILD_UNIT_SRU : `SILD_UNIT_INT;
                  d_crf  = 1'b1;
               end
               `SILD_X_ADD:
                  d_unit = use_sru ? `SILD_UNIT_SRU : `SILD_UNIT_INT;
               `SILD_X_TRAPW:
                  d_lat = `SILD_LAT_2;
               `SILD_X_MULHU:
                  d_lat = mul_lat(op_b, 1'b0, `SILD_MULHU_MAX);
               `SILD_X_MULHS, `SILD_X_MULLO:
                  d_lat = mul_lat(op_b, 1'b1, `SILD_MULS_MAX);
               `SILD_X_DIVU, `SILD_X_DIVS:
                  d_lat = `SILD_LAT_DIV;
               `SILD_X64_A, `SILD_X64_B, `SILD_X64_C, `SILD_X64_D, `SILD_X64_E,
               `SILD_X64_F, `SILD_X64_G, `SILD_X64_H, `SILD_X64_I:
               begin
                  d_ill  = 1'b1;
                  d_unit = `SILD_UNIT_NONE;
               end
               default:
                  d_lat = `SILD_LAT_1;
            endcase
         end
         default:
         begin
            if ((pri >= `SILD_P_LOG_LO) && (pri <= `SILD_P_LOG_HI))
               d_lat = `SILD_LAT_1;
            else
            begin
               // branch, float and load/store belong to other decoders
               d_known = 1'b0;
               d_unit  = `SILD_UNIT_NONE;
            end
         end
      endcase
      if (d_ill)
      begin
         d_unit = `SILD_UNIT_NONE;
         d_ser  = 1'b0;
         d_crf  = 1'b0;
      end
   end

   reg  [2:0] state_ff;
   reg  [2:0] nxt_state;
   reg  [7:0] nxt_total;
   reg  [7:0] run_ff;
   reg  [7:0] nxt_run;
   reg        nxt_res;
   wire       take    = dec_valid && accept_ff;
   wire       start   = take && d_known && !d_ill;
   wire       lat_done;

   sild_lat_timer u_timer
   (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .load     (start),
      .load_val (d_lat),
      .done_ff  (lat_done)
   );

   always @*
   begin
      nxt_state = state_ff;
      nxt_res   = 1'b0;
      nxt_run   = run_ff;
      nxt_total = total_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (start)
            begin
               nxt_state = ST_EXEC;
               nxt_run   = 8'h01;
            end
         end
         ST_EXEC:
         begin
            if (lat_done)
            begin
               if (serial_ff)
               begin
                  nxt_state = ST_SER;
                  nxt_run   = run_ff + 8'h01;
               end
               else
               begin
                  nxt_state = ST_IDLE;
                  nxt_res   = 1'b1;
                  nxt_total = run_ff;
               end
            end
            else
               nxt_run = run_ff + 8'h01;
         end
         ST_SER:
         begin
            // wait is open ended; completion logic owns the release
            if (ser_release)
            begin
               nxt_state = ST_IDLE;
               nxt_res   = 1'b1;
               nxt_total = run_ff;
            end
            else if (run_ff != 8'hff)
               nxt_run = run_ff + 8'h01;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff     <= ST_IDLE;
         run_ff       <= 8'h00;
         accept_ff    <= 1'b0;
         unit_ff      <= `SILD_UNIT_NONE;
         lat_ff       <= 5'h00;
         serial_ff    <= 1'b0;
         cr_fwd_ff    <= 1'b0;
         illegal_ff   <= 1'b0;
         foreign_ff   <= 1'b0;
         res_valid_ff <= 1'b0;
         total_ff     <= 8'h00;
      end
      else
      begin
         state_ff     <= nxt_state;
         run_ff       <= nxt_run;
         res_valid_ff <= nxt_res;
         total_ff     <= nxt_total;
         accept_ff    <= (nxt_state == ST_IDLE);
         illegal_ff   <= take && d_ill;
         foreign_ff   <= take && !d_known && !d_ill;
         if (start)
         begin
            unit_ff   <= d_unit;
            lat_ff    <= d_lat;
            serial_ff <= d_ser;
            cr_fwd_ff <= d_crf;
         end
      end
   end
endmodule

/* File: dv/sild_decoder_asserts.sv */
// assertion checker on the latency decoder ports
`timescale 1ns/1ps
module sild_chk
(
   input wire       ref_clk,
   input wire       rst_b,
   input wire       dec_valid,
   input wire       ser_release,
   input wire       accept_ff,
   input wire [2:0] unit_ff,
   input wire [4:0] lat_ff,
   input wire       serial_ff,
   input wire       cr_fwd_ff,
   input wire       illegal_ff,
   input wire       foreign_ff,
   input wire       res_valid_ff,
   input wire [7:0] total_ff
);
   reg        [7:0] cnt_ff;
   wire       [7:0] lat8 = {3'h0, lat_ff};
   // own count of cycles since the take edge, independent of the design's total
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         cnt_ff <= 8'h00;
      else if (accept_ff && dec_valid)
         cnt_ff <= 8'h00;
      else if (!accept_ff && cnt_ff != 8'hff)
         cnt_ff <= cnt_ff + 8'h01;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_take;
      accept_ff && dec_valid;
   endsequence
   sequence s_fixed_due;
      !accept_ff && !serial_ff && cnt_ff + 8'h01 == lat8;
   endsequence
   sequence s_released;
      !accept_ff && serial_ff && cnt_ff >= lat8 && ser_release;
   endsequence
   AST_TAKE: assert property (s_take |=> accept_ff == (illegal_ff || foreign_ff))
      else $error("take started the wrong kind of instruction");
   AST_FIXED_DUE: assert property (s_fixed_due |=> res_valid_ff)
      else $error("fixed latency result late");
   AST_NOT_EARLY: assert property (res_valid_ff && !serial_ff |-> cnt_ff == lat8)
      else $error("fixed latency result at wrong cycle");
   AST_TOTAL: assert property (res_valid_ff |-> total_ff == cnt_ff)
      else $error("total cycle count wrong");
   AST_SER_HOLD: assert property (res_valid_ff && serial_ff |-> cnt_ff > lat8 && $past(ser_release))
      else $error("serial result without release");
   AST_SER_DONE: assert property (s_released |=> res_valid_ff)
      else $error("release in wait did not finish");
   AST_RES_PULSE: assert property (res_valid_ff |-> accept_ff ##1 !res_valid_ff)
      else $error("result pulse or idle wrong");
   AST_FLAG_IDLE: assert property (illegal_ff || foreign_ff |-> accept_ff && !res_valid_ff)
      else $error("rejected instruction executed");
   AST_REFUSE: assert property (!accept_ff && dec_valid |=> !illegal_ff && !foreign_ff)
      else $error("request while busy left a trace");
   AST_CR_FWD: assert property (cr_fwd_ff |-> lat_ff == 5'h01 && !serial_ff)
      else $error("condition forward on wrong latency");
   AST_SER_UNIT: assert property (serial_ff |-> unit_ff == 3'h2)
      else $error("serializing instruction off the sysreg unit");
endmodule
bind sild_decoder sild_chk u_chk (.ref_clk, .rst_b, .dec_valid, .ser_release, .accept_ff,
   .unit_ff, .lat_ff, .serial_ff, .cr_fwd_ff, .illegal_ff, .foreign_ff, .res_valid_ff,
   .total_ff);

/* File: dv/sild_exec_model.sv */
// behavioural model of the execution units beside the latency decoder
`timescale 1ns/1ps
module sild_exec_model
(
   input  wire       ref_clk,
   input  wire       rst_b,
   input  wire       accept_ff,
   input  wire       serial_ff,
   input  wire       cmd_int,
   input  wire       cmd_sru,
   input  wire [3:0] ser_dly,
   output wire       int_busy,
   output wire       sru_busy,
   output wire       ser_release
);
   reg        [3:0] wait_ff;
   // busy levels are commanded so the bench can steer compares and adds
   assign int_busy    = cmd_int;
   assign sru_busy    = cmd_sru;
   // release only after the commanded drain time, low again once idle
   assign ser_release = serial_ff && !accept_ff && wait_ff >= ser_dly;
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         wait_ff <= 4'h0;
      else if (accept_ff)
         wait_ff <= 4'h0;
      else if (wait_ff != 4'hf)
         wait_ff <= wait_ff + 4'h1;
endmodule

/* File: dv/sild_decoder_tb.sv */
// self-checking bench for the latency decoder
`timescale 1ns/1ps
`include "sild_defs.vh"
module sild_decoder_tb;
   localparam [2:0]  SR  = `SILD_UNIT_SRU;
   localparam [2:0]  IU  = `SILD_UNIT_INT;
   localparam [5:0]  P19 = `SILD_P_GRP19;
   localparam [5:0]  P31 = `SILD_P_GRP31;
   localparam [31:0] Z   = 32'h0000_0000;
   reg         ref_clk;
   reg         rst_b;
   reg         dec_valid;
   reg  [31:0] dec_instr;
   reg  [31:0] op_b;
   reg         cmd_int;
   reg         cmd_sru;
   reg  [3:0]  ser_dly;
   wire        int_busy;
   wire        sru_busy;
   wire        ser_release;
   wire        accept_ff;
   wire [2:0]  unit_ff;
   wire [4:0]  lat_ff;
   wire        serial_ff;
   wire        cr_fwd_ff;
   wire        illegal_ff;
   wire        foreign_ff;
   wire        res_valid_ff;
   wire [7:0]  total_ff;
   integer     n_errors;
   integer     checks;
   integer     cyc;
   integer     t0;
   reg  [7:0]  g_total;
   reg  [2:0]  g_kind;
   sild_decoder DUT (.ref_clk, .rst_b, .dec_valid, .dec_instr, .op_b, .int_busy, .sru_busy,
      .ser_release, .accept_ff, .unit_ff, .lat_ff, .serial_ff, .cr_fwd_ff, .illegal_ff,
      .foreign_ff, .res_valid_ff, .total_ff);
   sild_exec_model u_units (.ref_clk, .rst_b, .accept_ff, .serial_ff, .cmd_int, .cmd_sru,
      .ser_dly, .int_busy, .sru_busy, .ser_release);
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      cyc <= cyc + 1;
   function [31:0] fp(input [5:0] p);
      fp = {p, 26'h000_0000};
   endfunction
   function [31:0] fx(input [5:0] p, input [9:0] x);
      fx = {p, 15'h0000, x, 1'b0};
   endfunction
   // special register number is split in two swapped halves
   function [31:0] fs(input [9:0] x, input [9:0] n);
      fs = {P31, 5'h00, n[4:0], n[9:5], x, 1'b0};
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one request, held until the take edge; t0 marks that edge
   task go(input [31:0] ins, input [31:0] ob);
      @(negedge ref_clk);
      while (accept_ff !== 1'b1)
         @(negedge ref_clk);
      @(posedge ref_clk);
      dec_valid <= 1'b1;
      dec_instr <= ins;
      op_b      <= ob;
      @(posedge ref_clk);
      dec_valid <= 1'b0;
      t0 = cyc;
   endtask
   task fin;
      integer k;
      g_kind = 3'h0;
      for (k = 0; k < 300 && g_kind === 3'h0; k = k + 1)
      begin
         @(negedge ref_clk);
         g_kind = {res_valid_ff, illegal_ff, foreign_ff};
      end
      g_total = 8'(cyc - t0 - 1);
   endtask
   task ex(input [31:0] ins, input [31:0] ob, input [2:0] u, input [4:0] l, input [1:0] sc);
      go(ins, ob);
      fin;
      chk({5'h00, g_kind}, 8'h04);
      chk({5'h00, unit_ff}, {5'h00, u});
      chk({3'h0, lat_ff}, {3'h0, l});
      chk({6'h00, serial_ff, cr_fwd_ff}, {6'h00, sc});
      chk(total_ff, g_total);
      chk({7'h00, sc[1] ? total_ff > {3'h0, l} : total_ff == {3'h0, l}}, 8'h01);
   endtask
   task sr(input [31:0] ins, input [4:0] l, input [1:0] sc);
      ex(ins, Z, SR, l, sc);
   endtask
   task iu(input [31:0] ins, input [31:0] ob, input [4:0] l, input [1:0] sc);
      ex(ins, ob, IU, l, sc);
   endtask
   task t_sysreg;
      sr(fp(`SILD_P_SYSCALL), 5'h03, 2'h0);
      sr(fx(P19, `SILD_X_RFI), 5'h03, 2'h0);
      sr(fx(P19, `SILD_X_ISYNC), 5'h01, 2'h2);
      sr(fx(P31, `SILD_X_WRMSR), 5'h02, 2'h0);
      sr(fx(P31, `SILD_X_WRSEGI), 5'h02, 2'h0);
      sr(fs(`SILD_X_RDSPR, 10'h008), 5'h01, 2'h0);
      sr(fs(`SILD_X_RDSPR, `SILD_SPR_DBAT_HI), 5'h03, 2'h2);
      sr(fs(`SILD_X_RDSPR, `SILD_SPR_IBAT_LO), 5'h03, 2'h2);
      sr(fs(`SILD_X_WRSPR, 10'h008), 5'h02, 2'h0);
      sr(fs(`SILD_X_WRSPR, `SILD_SPR_XER), 5'h02, 2'h2);
      sr(fs(`SILD_X_WRSPR, `SILD_SPR_IBAT_HI), 5'h02, 2'h2);
      sr(fx(P31, `SILD_X_RDSEG), 5'h03, 2'h2);
      sr(fx(P31, `SILD_X_MSYNC), 5'h01, 2'h2);
      sr(fx(P31, `SILD_X_IOBAR), 5'h01, 2'h0);
      sr(fx(P31, `SILD_X_RDTB), 5'h01, 2'h0);
      sr(fs(`SILD_X_WRSPR, `SILD_SPR_TBL), 5'h01, 2'h0);
      sr(fx(P19, `SILD_X_CRXOR), 5'h01, 2'h0);
      sr(fx(P19, `SILD_X_CPCF), 5'h01, 2'h0);
      sr(fx(P19, `SILD_X_CROR), 5'h01, 2'h0);
      sr(fx(P31, `SILD_X_RDCR), 5'h01, 2'h0);
      sr(fx(P31, `SILD_X_WRCRF), 5'h01, 2'h0);
      sr(fx(P31, `SILD_X_XCPCR), 5'h01, 2'h2);
   endtask
   task t_int;
      iu(fp(`SILD_P_CMPI), Z, 5'h01, 2'h1);
      iu(fx(P31, `SILD_X_CMPL), Z, 5'h01, 2'h1);
      iu(fp(`SILD_P_TRAPI), Z, 5'h02, 2'h0);
      iu(fx(P31, `SILD_X_TRAPW), Z, 5'h02, 2'h0);
      iu(fx(P31, `SILD_X_DIVU), Z, 5'h14, 2'h0);
      iu(fx(P31, `SILD_X_DIVS), Z, 5'h14, 2'h0);
      iu(fp(`SILD_P_ROTM), Z, 5'h01, 2'h0);
      iu(fx(P31, 10'h01a), Z, 5'h01, 2'h0);
      iu(fx(P31, 10'h39a), Z, 5'h01, 2'h0);
      iu(fp(`SILD_P_MULI), 32'h0000_0005, 5'h02, 2'h0);
      iu(fp(`SILD_P_MULI), 32'h0001_0000, 5'h03, 2'h0);
      iu(fx(P31, `SILD_X_MULHU), 32'hffff_ffff, 5'h05, 2'h0);
      iu(fx(P31, `SILD_X_MULHU), Z, 5'h02, 2'h0);
      iu(fx(P31, `SILD_X_MULHS), 32'h0000_1234, 5'h03, 2'h0);
      iu(fx(P31, `SILD_X_MULLO), 32'h7fff_ffff, 5'h05, 2'h0);
   endtask
   // integer unit busy, sysreg unit free then busy: only compares and plain add move over, and only while it is free
   task t_steer;
      @(posedge ref_clk);
      cmd_int <= 1'b1;
      ex(fx(P31, `SILD_X_CMP), Z, SR, 5'h01, 2'h1);
      sr(fx(P31, `SILD_X_ADD), 5'h01, 2'h0);
      iu(fx(P31, 10'h028), Z, 5'h01, 2'h0);
      @(posedge ref_clk);
      cmd_sru <= 1'b1;
      iu(fx(P31, `SILD_X_ADD), Z, 5'h01, 2'h0);
      @(posedge ref_clk);
      cmd_int <= 1'b0;
      cmd_sru <= 1'b0;
   endtask
   task t_serial;
      @(posedge ref_clk);
      ser_dly <= 4'h6;
      sr(fx(P31, `SILD_X_MSYNC), 5'h01, 2'h2);
      chk(total_ff, 8'h07);
      @(posedge ref_clk);
      ser_dly <= 4'h0;
      sr(fx(P19, `SILD_X_ISYNC), 5'h01, 2'h2);
      chk(total_ff, 8'h02);
   endtask
   task t_bad;
      go(fp(`SILD_P64_A), Z);
      fin;
      chk({5'h00, g_kind}, 8'h02);
      go(fx(P31, `SILD_X64_I), Z);
      fin;
      chk({5'h00, g_kind}, 8'h02);
      chk({7'h00, accept_ff}, 8'h01);
      go(fx(P19, 10'h010), Z);
      fin;
      chk({5'h00, g_kind}, 8'h01);
      // a 64-bit encoding offered mid-divide must vanish without trace
      go(fx(P31, `SILD_X_DIVU), Z);
      @(posedge ref_clk);
      dec_valid <= 1'b1;
      dec_instr <= fp(`SILD_P64_B);
      @(posedge ref_clk);
      dec_valid <= 1'b0;
      fin;
      chk({5'h00, g_kind}, 8'h04);
      chk(total_ff, 8'h14);
   endtask
   initial
   begin
      ref_clk   = 1'b0;
      rst_b     = 1'b0;
      dec_valid = 1'b0;
      dec_instr = Z;
      op_b      = Z;
      cmd_int   = 1'b0;
      cmd_sru   = 1'b0;
      ser_dly   = 4'h2;
      n_errors  = 0;
      checks    = 0;
      cyc       = 0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_sysreg;
      t_int;
      t_steer;
      t_serial;
      t_bad;
      end_sim;
   end
   // about fifty instructions of under thirty cycles each; ample margin
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      n_errors = n_errors + 1;
      end_sim;
   end
endmodule
